// file: inc/fepdc_pkg.sv
// Package: map, field positions and carrier types of the front-end config bank
package fepdc_pkg;

	// ----------------------------------------
	// Register indexes (byte address is four times the index)
	// ----------------------------------------
	localparam logic [7:0] IDX_TERM = 8'h34;
	localparam logic [7:0] IDX_PWR = 8'h35;
	localparam logic [7:0] IDX_DOP = 8'h36;
	localparam logic [7:0] IDX_PHL = 8'h37;
	localparam logic [7:0] IDX_PHH = 8'h38;
	localparam logic [7:0] IDX_GAIN = 8'h39;
	localparam logic [7:0] IDX_HPF = 8'h3B;
	localparam logic [7:0] IDX_STAT = 8'h3C;
	localparam int NREG = 7;
	localparam logic [2:0] SL_TERM = 3'h0;
	localparam logic [2:0] SL_PWR = 3'h1;
	localparam logic [2:0] SL_DOP = 3'h2;
	localparam logic [2:0] SL_PHL = 3'h3;
	localparam logic [2:0] SL_PHH = 3'h4;
	localparam logic [2:0] SL_GAIN = 3'h5;
	localparam logic [2:0] SL_HPF = 3'h6;
	localparam logic [15:0] REG_RST = 16'h0000;
	// Writable bits per slot; reserved bits hold zero
	localparam logic [NREG-1:0][15:0] WR_MASK = {16'h03FC, 16'hFFFF, 16'hFFFF,
		16'hFFFF, 16'h0F7F, 16'hFCFF, 16'hF7FF};

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int P_IMP = 0;
	localparam int P_INDIV = 5;
	localparam int P_PRESET = 6;
	localparam int P_TERM_ON = 8;
	localparam int P_GGAIN = 13;
	localparam int P_OVR = 15;
	localparam int P_RED = 10;
	localparam int P_MED = 11;
	localparam int P_AGS_PD = 12;
	localparam int P_LNA_PD = 13;
	localparam int P_QSLP = 14;
	localparam int P_DSLP = 15;
	localparam int P_FB = 0;
	localparam int P_FAST = 5;
	localparam int P_BASE = 6;
	localparam int P_PATH = 8;
	localparam int P_SUM_OFF = 9;
	localparam int P_RATIO = 10;
	localparam int P_HPF = 2;
	localparam int P_ATT = 4;
	localparam int P_ATT_ON = 7;
	localparam int P_SUM_PWR = 8;
	localparam int P_OBS = 9;

	// ----------------------------------------
	// Codes
	// ----------------------------------------
	localparam logic [1:0] GAIN_18 = 2'h0;
	localparam logic [1:0] GAIN_24 = 2'h1;
	localparam logic [1:0] GAIN_12 = 2'h2;
	// Resistor sets for presets 11,10,01,00 at each preamp gain
	localparam logic [19:0] PRE_24 = {5'h08, 5'h04, 5'h02, 5'h01};
	localparam logic [19:0] PRE_18 = {5'h18, 5'h1C, 5'h0E, 5'h07};
	localparam logic [19:0] PRE_12 = {5'h0C, 5'h06, 5'h03, 5'h00};

	typedef enum logic [1:0] {
		PM_LOW_NOISE = 2'b00,
		PM_LOW_POWER = 2'b01,
		PM_MEDIUM = 2'b10
	} fepdc_pm_t;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		fepdc_pm_t mode;
		logic mode_conflict;
		logic lna_pd;
		logic vcat_pga_pd;
		logic quick_sleep;
		logic deep_sleep;
	} fepdc_pwr_t;

	typedef struct packed {
		logic doppler_mode;
		logic summer_en;
		logic [4:0] summer_fb;
		logic fast_clk_cmos;
		logic base_clk_cmos;
		logic [1:0] clk_ratio;
		logic observe;
		logic [31:0] mixer_phase;
	} fepdc_dop_t;

	typedef struct packed {
		logic [15:0] preamp_gain;
		logic [4:0] fb_res_en;
		logic [1:0] hpf_corner;
		logic [2:0] dig_att;
	} fepdc_fe_t;

	typedef struct packed {
		logic [NREG-1:0][15:0] regs;
		logic wr_pend;
		logic [2:0] wr_slot;
		logic [31:0] hrdata;
		fepdc_pwr_t pwr;
		fepdc_dop_t dop;
		fepdc_fe_t fe;
	} fepdc_state_t;

endpackage

// file: design/fepdc_regs.sv
// Module: AHB-Lite configuration bank and decode for the front-end power and Doppler setup
//
// Chosen here: the AHB-Lite register port.

module fepdc_regs (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// AHB-Lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	// Decoded controls to the analog front end
	output fepdc_pkg::fepdc_pwr_t pwr_o,
	output fepdc_pkg::fepdc_dop_t dop_o,
	output fepdc_pkg::fepdc_fe_t fe_o
);
	import fepdc_pkg::*;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Word index to slot; bit 3 marks a hit
	function automatic logic [3:0] idx_slot(input logic [7:0] idx);
		logic [3:0] r;
		r = 4'h0;
		case (idx)
			IDX_TERM: r = {1'b1, SL_TERM};
			IDX_PWR: r = {1'b1, SL_PWR};
			IDX_DOP: r = {1'b1, SL_DOP};
			IDX_PHL: r = {1'b1, SL_PHL};
			IDX_PHH: r = {1'b1, SL_PHH};
			IDX_GAIN: r = {1'b1, SL_GAIN};
			IDX_HPF: r = {1'b1, SL_HPF};
			default: r = 4'h0;
		endcase
		return r;
	endfunction

	// Preset termination and preamp gain to resistor set
	function automatic logic [4:0] preset_res(input logic [1:0] pre, input logic [1:0] g);
		logic [4:0] r;
		r = 5'h00;
		case (g)
			GAIN_24: r = PRE_24[5*pre +: 5];
			GAIN_18: r = PRE_18[5*pre +: 5];
			GAIN_12: r = PRE_12[5*pre +: 5];
			default: r = 5'h00;
		endcase
		return r;
	endfunction

	fepdc_state_t s_ff;
	fepdc_state_t nxt_s;
	logic [3:0] hit_slot;
	logic addr_ok;
	logic [15:0] t, p, d, h;
	logic [15:0] stat;

	assign addr_ok = hsel_i && hready_i && htrans_i[1];
	assign hit_slot = idx_slot(haddr_i[9:2]);

	// Status word reflects decoded state currently driven
	always_comb begin
		stat = 16'h0000;
		stat[1:0] = s_ff.pwr.mode;
		stat[2] = s_ff.pwr.mode_conflict;
		stat[3] = s_ff.dop.summer_en;
		stat[4] = s_ff.dop.doppler_mode;
		stat[9:5] = s_ff.fe.fb_res_en;
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		nxt_s = s_ff;
		nxt_s.wr_pend = 1'b0;
		// Data-phase write commits; value held until rewritten
		if (s_ff.wr_pend) begin
			nxt_s.regs[s_ff.wr_slot] = hwdata_i[15:0] & WR_MASK[s_ff.wr_slot];
		end
		if (addr_ok) begin
			if (hwrite_i) begin
				nxt_s.wr_pend = hit_slot[3];
				nxt_s.wr_slot = hit_slot[2:0];
			end else if (hit_slot[3]) begin
				nxt_s.hrdata = {16'h0000, nxt_s.regs[hit_slot[2:0]]};
			end else if (haddr_i[9:2] == IDX_STAT) begin
				nxt_s.hrdata = {16'h0000, stat};
			end else begin
				nxt_s.hrdata = 32'h0000_0000;
			end
		end
		t = nxt_s.regs[SL_TERM];
		p = nxt_s.regs[SL_PWR];
		d = nxt_s.regs[SL_DOP];
		h = nxt_s.regs[SL_HPF];
		// Power mode; both selects set is invalid and falls back to low noise
		nxt_s.pwr.mode_conflict = p[P_RED] & p[P_MED];
		if (p[P_MED] && !p[P_RED]) begin
			nxt_s.pwr.mode = PM_MEDIUM;
		end else if (p[P_RED] && !p[P_MED]) begin
			nxt_s.pwr.mode = PM_LOW_POWER;
		end else begin
			nxt_s.pwr.mode = PM_LOW_NOISE;
		end
		// Path select never powers the attenuator down by itself
		nxt_s.pwr.vcat_pga_pd = p[P_AGS_PD];
		nxt_s.pwr.lna_pd = p[P_LNA_PD];
		nxt_s.pwr.quick_sleep = p[P_QSLP] & ~p[P_DSLP];
		nxt_s.pwr.deep_sleep = p[P_DSLP];
		nxt_s.dop.summer_fb = d[P_FB +: 5];
		nxt_s.dop.fast_clk_cmos = d[P_FAST];
		nxt_s.dop.base_clk_cmos = ~d[P_BASE];
		nxt_s.dop.doppler_mode = d[P_PATH];
		nxt_s.dop.clk_ratio = d[P_RATIO +: 2];
		nxt_s.dop.observe = h[P_OBS];
		// Summer: low-active enable in Doppler, power bit in imaging test
		if (d[P_PATH]) begin
			nxt_s.dop.summer_en = ~d[P_SUM_OFF];
		end else begin
			nxt_s.dop.summer_en = h[P_OBS] & h[P_SUM_PWR];
		end
		nxt_s.dop.mixer_phase = {nxt_s.regs[SL_PHH], nxt_s.regs[SL_PHL]};
		for (int c = 0; c < 8; c++) begin
			if (t[P_OVR]) begin
				nxt_s.fe.preamp_gain[2*c +: 2] = nxt_s.regs[SL_GAIN][2*c +: 2];
			end else begin
				nxt_s.fe.preamp_gain[2*c +: 2] = t[P_GGAIN +: 2];
			end
		end
		// Termination resistors: individual one-hot or preset decode
		if (!t[P_TERM_ON]) begin
			nxt_s.fe.fb_res_en = 5'h00;
		end else if (t[P_INDIV]) begin
			nxt_s.fe.fb_res_en = t[P_IMP +: 5];
		end else begin
			nxt_s.fe.fb_res_en = preset_res(t[P_PRESET +: 2], t[P_GGAIN +: 2]);
		end
		nxt_s.fe.hpf_corner = h[P_HPF +: 2];
		nxt_s.fe.dig_att = h[P_ATT_ON] ? h[P_ATT +: 3] : 3'h0;
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign hrdata_o = s_ff.hrdata;
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;
	assign pwr_o = s_ff.pwr;
	assign dop_o = s_ff.dop;
	assign fe_o = s_ff.fe;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	logic wr_pwr, wr_dop;
	assign wr_pwr = addr_ok && hwrite_i && haddr_i[9:2] == IDX_PWR;
	assign wr_dop = addr_ok && hwrite_i && haddr_i[9:2] == IDX_DOP;

	property p_medium;
		@(posedge clk_i) disable iff (sys_rst_i)
		(s_ff.regs[SL_PWR][P_MED] && !s_ff.regs[SL_PWR][P_RED]) |-> pwr_o.mode == PM_MEDIUM;
	endproperty
	a_medium: assert property (p_medium) else $error("medium power not selected");

	property p_ags_pd;
		@(posedge clk_i) disable iff (sys_rst_i)
		wr_pwr ##1 1'b1 |=> pwr_o.vcat_pga_pd == $past(hwdata_i[P_AGS_PD], 1);
	endproperty
	a_ags_pd: assert property (p_ags_pd) else $error("stage shutdown not applied");

	property p_lna_pd;
		@(posedge clk_i) disable iff (sys_rst_i)
		wr_pwr ##1 hwdata_i[P_LNA_PD] |=> pwr_o.lna_pd && pwr_o.vcat_pga_pd == $past(hwdata_i[P_AGS_PD], 1);
	endproperty
	a_lna_pd: assert property (p_lna_pd) else $error("preamp shutdown wrong");

	property p_deep;
		@(posedge clk_i) disable iff (sys_rst_i)
		s_ff.regs[SL_PWR][P_DSLP] |-> pwr_o.deep_sleep && !pwr_o.quick_sleep;
	endproperty
	a_deep: assert property (p_deep) else $error("deep sleep does not win");

	property p_summer;
		@(posedge clk_i) disable iff (sys_rst_i)
		dop_o.doppler_mode |-> dop_o.summer_en == !s_ff.regs[SL_DOP][P_SUM_OFF];
	endproperty
	a_summer: assert property (p_summer) else $error("summer enable wrong");

	property p_ratio;
		@(posedge clk_i) disable iff (sys_rst_i)
		wr_dop ##1 1'b1 |=> dop_o.clk_ratio == $past(hwdata_i[P_RATIO +: 2], 1);
	endproperty
	a_ratio: assert property (p_ratio) else $error("clock ratio not applied");

	property p_gain;
		@(posedge clk_i) disable iff (sys_rst_i)
		!s_ff.regs[SL_TERM][P_OVR] |-> fe_o.preamp_gain == {8{s_ff.regs[SL_TERM][P_GGAIN +: 2]}};
	endproperty
	a_gain: assert property (p_gain) else $error("global gain not used");

	property p_att;
		@(posedge clk_i) disable iff (sys_rst_i)
		!s_ff.regs[SL_HPF][P_ATT_ON] |-> fe_o.dig_att == 3'h0;
	endproperty
	a_att: assert property (p_att) else $error("attenuation while off");

	property p_lowpwr;
		@(posedge clk_i) disable iff (sys_rst_i)
		(p[P_RED] && !p[P_MED]) |=> pwr_o.mode == PM_LOW_POWER;
	endproperty
	a_lowpwr: assert property (p_lowpwr) else $error("low power not selected");

	property p_hold;
		@(posedge clk_i) disable iff (sys_rst_i)
		!s_ff.wr_pend |=> $stable(s_ff.regs);
	endproperty
	a_hold: assert property (p_hold) else $error("register changed without write");

	property p_unmapped;
		@(posedge clk_i) disable iff (sys_rst_i)
		(addr_ok && !hwrite_i && !hit_slot[3] && haddr_i[9:2] != IDX_STAT) |=> hrdata_o == 0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

	property p_quick;
		@(posedge clk_i) disable iff (sys_rst_i)
		(s_ff.regs[SL_PWR][P_QSLP] && !s_ff.regs[SL_PWR][P_DSLP]) |-> pwr_o.quick_sleep;
	endproperty
	a_quick: assert property (p_quick) else $error("quick sleep not applied");

	property p_fb;
		@(posedge clk_i) disable iff (sys_rst_i)
		wr_dop ##1 1'b1 |=> dop_o.summer_fb == $past(hwdata_i[P_FB +: 5], 1);
	endproperty
	a_fb: assert property (p_fb) else $error("summer feedback not applied");

	property p_fast;
		@(posedge clk_i) disable iff (sys_rst_i)
		wr_dop ##1 1'b1 |=> dop_o.fast_clk_cmos == $past(hwdata_i[P_FAST], 1);
	endproperty
	a_fast: assert property (p_fast) else $error("fast clock input type wrong");

	property p_base;
		@(posedge clk_i) disable iff (sys_rst_i)
		wr_dop ##1 1'b1 |=> dop_o.base_clk_cmos == !$past(hwdata_i[P_BASE], 1);
	endproperty
	a_base: assert property (p_base) else $error("base clock input type wrong");

	property p_path;
		@(posedge clk_i) disable iff (sys_rst_i)
		wr_dop ##1 1'b1 |=> dop_o.doppler_mode == $past(hwdata_i[P_PATH], 1);
	endproperty
	a_path: assert property (p_path) else $error("path select not applied");

	property p_path_ags;
		@(posedge clk_i) disable iff (sys_rst_i)
		(dop_o.doppler_mode && !s_ff.regs[SL_PWR][P_AGS_PD]) |-> !pwr_o.vcat_pga_pd;
	endproperty
	a_path_ags: assert property (p_path_ags) else $error("stages shut by path");

	property p_phase_lo;
		@(posedge clk_i) disable iff (sys_rst_i)
		(s_ff.wr_pend && s_ff.wr_slot == SL_PHL) |=>
			dop_o.mixer_phase[15:0] == $past(hwdata_i[15:0], 1);
	endproperty
	a_phase_lo: assert property (p_phase_lo) else $error("low phase not applied");

	property p_phase_hi;
		@(posedge clk_i) disable iff (sys_rst_i)
		(s_ff.wr_pend && s_ff.wr_slot == SL_PHH) |=>
			dop_o.mixer_phase[31:16] == $past(hwdata_i[15:0], 1);
	endproperty
	a_phase_hi: assert property (p_phase_hi) else $error("high phase not applied");

	property p_override;
		@(posedge clk_i) disable iff (sys_rst_i)
		s_ff.regs[SL_TERM][P_OVR] |-> fe_o.preamp_gain == s_ff.regs[SL_GAIN];
	endproperty
	a_override: assert property (p_override) else $error("channel gain not used");

	property p_hpf;
		@(posedge clk_i) disable iff (sys_rst_i)
		(s_ff.wr_pend && s_ff.wr_slot == SL_HPF) |=>
			fe_o.hpf_corner == $past(hwdata_i[P_HPF +: 2], 1);
	endproperty
	a_hpf: assert property (p_hpf) else $error("corner not applied");

	property p_att_on;
		@(posedge clk_i) disable iff (sys_rst_i)
		s_ff.regs[SL_HPF][P_ATT_ON] |-> fe_o.dig_att == s_ff.regs[SL_HPF][P_ATT +: 3];
	endproperty
	a_att_on: assert property (p_att_on) else $error("attenuation step wrong");

	property p_sum_img;
		@(posedge clk_i) disable iff (sys_rst_i)
		(!dop_o.doppler_mode && !dop_o.observe) |-> !dop_o.summer_en;
	endproperty
	a_sum_img: assert property (p_sum_img) else $error("summer on in imaging");

	property p_observe;
		@(posedge clk_i) disable iff (sys_rst_i)
		(s_ff.wr_pend && s_ff.wr_slot == SL_HPF) |=>
			dop_o.observe == $past(hwdata_i[P_OBS], 1);
	endproperty
	a_observe: assert property (p_observe) else $error("observe not applied");

	property p_onehot;
		@(posedge clk_i) disable iff (sys_rst_i)
		(s_ff.regs[SL_TERM][P_TERM_ON] && s_ff.regs[SL_TERM][P_INDIV]) |->
			fe_o.fb_res_en == s_ff.regs[SL_TERM][P_IMP +: 5];
	endproperty
	a_onehot: assert property (p_onehot) else $error("resistor field not used");

	property p_term_off;
		@(posedge clk_i) disable iff (sys_rst_i)
		!s_ff.regs[SL_TERM][P_TERM_ON] |-> fe_o.fb_res_en == 5'h00;
	endproperty
	a_term_off: assert property (p_term_off) else $error("resistor on while off");

	property p_preset;
		@(posedge clk_i) disable iff (sys_rst_i)
		(s_ff.regs[SL_TERM][P_TERM_ON] && !s_ff.regs[SL_TERM][P_INDIV]
			&& s_ff.regs[SL_TERM][P_GGAIN +: 2] == GAIN_24) |-> $onehot(fe_o.fb_res_en);
	endproperty
	a_preset: assert property (p_preset) else $error("preset decode wrong");

	property p_rd_mask;
		@(posedge clk_i) disable iff (sys_rst_i)
		(addr_ok && !hwrite_i && hit_slot[3]) |=> hrdata_o[31:16] == 16'h0000
			&& (hrdata_o[15:0] & ~WR_MASK[$past(hit_slot[2:0], 1)]) == 16'h0000;
	endproperty
	a_rd_mask: assert property (p_rd_mask) else $error("reserved bits read set");

	c_doppler: cover property (@(posedge clk_i) disable iff (sys_rst_i)
		dop_o.doppler_mode && dop_o.summer_en);
	c_override: cover property (@(posedge clk_i) disable iff (sys_rst_i)
		s_ff.regs[SL_TERM][P_OVR] && fe_o.preamp_gain != 16'h0000);
	c_sleep: cover property (@(posedge clk_i) disable iff (sys_rst_i)
		pwr_o.quick_sleep ##1 pwr_o.deep_sleep);
	c_preset: cover property (@(posedge clk_i) disable iff (sys_rst_i)
		s_ff.regs[SL_TERM][P_TERM_ON] && !s_ff.regs[SL_TERM][P_INDIV] && fe_o.fb_res_en != 5'h00);
	c_observe: cover property (@(posedge clk_i) disable iff (sys_rst_i)
		!dop_o.doppler_mode && dop_o.observe && dop_o.summer_en);

endmodule

// file: sim/tb_front_end_power_and_doppler_config.sv
// Testbench: AHB-Lite checks of the front-end power and Doppler config bank
module tb_front_end_power_and_doppler_config;
	timeunit 1ns;
	timeprecision 1ps;
	import fepdc_pkg::*;

	logic clk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hrdy;
	logic hresp;
	fepdc_pwr_t pwr;
	fepdc_dop_t dop;
	fepdc_fe_t fe;
	int n_fail = 0;
	int n_checks = 0;
	logic [31:0] rd;

	always #5 clk = ~clk;

	fepdc_regs fepdc_regs_i (.clk_i(clk), .sys_rst_i(rst), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
		.hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp),
		.pwr_o(pwr), .dop_o(dop), .fe_o(fe));

	// ----------------------------------------
	// Bus and compare tasks
	// ----------------------------------------
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask

	// Wait for hready under a bound
	task automatic step();
		int k;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (hrdy !== 1'b1 && k < 20);
		if (hrdy !== 1'b1) begin
			chk("hready", 64'h1, {63'h0, hrdy});
			test_done();
		end
	endtask

	// One single transfer; returns at the falling edge after the data phase
	task automatic xfer(input logic w, input logic [7:0] idx, input logic [15:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {22'h0, idx, 2'h0};
		htrans <= 2'h2;
		hwrite <= w;
		step();
		htrans <= 2'h0;
		hwdata <= {16'h0, d};
		step();
		rd = hrdata;
		@(negedge clk);
	endtask

	task automatic wrc(input logic [7:0] idx, input logic [15:0] d, input logic [15:0] e);
		xfer(1'b1, idx, d);
		xfer(1'b0, idx, 16'h0);
		chk("readback", {48'h0, e}, {32'h0, rd});
	endtask

	task automatic pw(input logic [15:0] d, input logic [6:0] e);
		wrc(IDX_PWR, d, d & 16'hFCFF);
		chk("power decode", e, pwr);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		logic [7:0] ix [6] = '{IDX_PWR, IDX_DOP, IDX_PHL, IDX_PHH, IDX_GAIN, IDX_HPF};
		foreach (ix[i]) begin
			xfer(1'b0, ix[i], 16'h0);
			chk("reset value", 64'h0, rd);
		end
		chk("pwr", 64'h0, pwr);
		chk("fast clk cmos", 64'h0, dop.fast_clk_cmos);
		chk("base clk cmos", 64'h1, dop.base_clk_cmos);
		chk("hresp", 64'h0, hresp);
		$display("test reset done");
	endtask

	task automatic t_power();
		pw(16'h0800, 7'h40);
		pw(16'h0400, 7'h20);
		pw(16'h0C00, 7'h10);
		xfer(1'b0, IDX_STAT, 16'h0);
		chk("status", 64'h4, rd);
		xfer(1'b1, IDX_STAT, 16'hFFFF);
		xfer(1'b0, IDX_STAT, 16'h0);
		chk("status read only", 64'h4, rd);
		pw(16'h1000, 7'h04);
		pw(16'h2000, 7'h08);
		pw(16'h4000, 7'h02);
		pw(16'hC000, 7'h01);
		pw(16'hFFFF, 7'h1D);
		pw(16'h0000, 7'h00);
		$display("test power done");
	endtask

	task automatic t_dop();
		logic [1:0] r;
		logic [15:0] d;
		for (int i = 0; i < 4; i++) begin
			r = 2'(i);
			d = {4'h0, r, r[0], 1'b1, 1'b1, r[1], ~r[1], r, 3'h5};
			wrc(IDX_DOP, d, d & 16'h0F7F);
			chk("ratio", r, dop.clk_ratio);
			chk("fb", {r, 3'h5}, dop.summer_fb);
			chk("fast", !r[1], dop.fast_clk_cmos);
			chk("base", !r[1], dop.base_clk_cmos);
			chk("mode", 64'h1, dop.doppler_mode);
			chk("ags pd", 64'h0, pwr.vcat_pga_pd);
			chk("sum en", !r[0], dop.summer_en);
		end
		wrc(IDX_DOP, 16'h0200, 16'h0200);
		wrc(IDX_HPF, 16'h0300, 16'h0300);
		chk("mode", 64'h0, dop.doppler_mode);
		chk("sum en", 64'h1, dop.summer_en);
		chk("observe", 64'h1, dop.observe);
		wrc(IDX_HPF, 16'h0200, 16'h0200);
		chk("sum en", 64'h0, dop.summer_en);
		$display("test doppler done");
	endtask

	task automatic t_gain();
		wrc(IDX_PHL, 16'hF7A0, 16'hF7A0);
		wrc(IDX_PHH, 16'h0F5C, 16'h0F5C);
		chk("phase", 64'h0F5CF7A0, dop.mixer_phase);
		wrc(IDX_TERM, 16'h2800, 16'h2000);
		wrc(IDX_GAIN, 16'h9C63, 16'h9C63);
		chk("gain", 64'h5555, fe.preamp_gain);
		wrc(IDX_TERM, 16'hA000, 16'hA000);
		chk("gain", 64'h9C63, fe.preamp_gain);
		$display("test phase and gain done");
	endtask

	task automatic t_term();
		logic [15:0] d;
		logic [19:0] t;
		for (int i = 0; i < 5; i++) begin
			d = 16'h0120 | (16'h1 << i);
			wrc(IDX_TERM, d, d);
			chk("one hot", 5'h1 << i, fe.fb_res_en);
		end
		for (int g = 0; g < 3; g++) begin
			t = (g == 0) ? PRE_18 : (g == 1) ? PRE_24 : PRE_12;
			for (int p = 0; p < 4; p++) begin
				d = {1'b0, 2'(g), 4'h0, 1'b1, 2'(p), 6'h0};
				wrc(IDX_TERM, d, d);
				chk("preset", t[p*5 +: 5], fe.fb_res_en);
			end
		end
		wrc(IDX_TERM, 16'h0021, 16'h0021);
		chk("term off", 64'h0, fe.fb_res_en);
		$display("test termination done");
	endtask

	task automatic t_hpf();
		logic [1:0] c;
		logic [15:0] d;
		for (int i = 0; i < 4; i++) begin
			c = 2'(i);
			d = {8'h0, c[0], c, 1'b1, c, 2'h3};
			wrc(IDX_HPF, d, d & 16'h03FC);
			chk("corner", c, fe.hpf_corner);
			chk("atten", c[0] ? {c, 1'b1} : 3'h0, fe.dig_att);
		end
		xfer(1'b1, 8'h3A, 16'hFFFF);
		xfer(1'b0, 8'h3A, 16'h0);
		chk("unmapped", 64'h0, rd);
		xfer(1'b0, IDX_PHL, 16'h0);
		chk("hold", 64'hF7A0, rd);
		$display("test highpass done");
	endtask

	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_power();
		t_dop();
		t_gain();
		t_term();
		t_hpf();
		test_done();
	end
endmodule
